// ===== tma_map.svh
// Address map, field positions, encodings and reset values of the timer control block.
// Assumes a byte-wide register port with a 10-bit byte address.
`ifndef TMA_MAP_SVH
`define TMA_MAP_SVH

`define TMA_NTIMERS 5
`define TMA_ADDR_W 10
`define TMA_A_START 10'h380
`define TMA_A_ONESHOT 10'h382
`define TMA_A_TRIG4 10'h383
`define TMA_A_DIR 10'h384
`define TMA_A_RELOAD 10'h386
`define TMA_A_MODE 10'h398
`define TMA_RESET_BYTE 8'h00
`define TMA_RESET_WORD 16'h0000
`define TMA_CNT_MAX 16'hFFFF
`define TMA_CNT_ZERO 16'h0000
`define TMA_DIR_LSB 0
`define TMA_QUAD_LSB 5
`define TMA_QUAD_MSB 7
`define TMA_TRIG_LSB 6
`define TMA_TRIG_MSB 7
`define TMA_MODE_LSB 0
`define TMA_MODE_MSB 1
`define TMA_DSRC_BIT 4
`define TMA_MODE_TIMER 2'h0
`define TMA_MODE_EVENT 2'h1
`define TMA_MODE_ONESHOT 2'h2
`define TMA_MODE_PWM 2'h3
`define TMA_TRIG_PIN 2'h0
`define TMA_TRIG_BAD 2'h1
`define TMA_TRIG_OVFA 2'h2
`define TMA_TRIG_OVFB 2'h3

`endif

// ===== tma_pkg.sv
// Types shared by the timer control block and its timers.
// Assumes tma_map.svh sits beside it.
`default_nettype none
package tma_pkg;
  // Control registers of the top module
  typedef struct packed {
    logic [4:0] start;
    logic [4:0] dir;
    logic [2:0] quad;
    logic [1:0] trig0;
    logic [1:0] trig4;
    logic [4:0][2:0] mode;
    logic [4:0][15:0] reload;
    logic [4:0] go;
    logic [7:0] rdata;
  } tma_ctrl_type;

  // One timer's counting state
  typedef struct packed {
    logic [15:0] count;
    logic run;
    logic out;
    logic ovf;
  } tma_core_type;

  // Three-stage pin synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } tma_sync_type;
endpackage : tma_pkg
`default_nettype wire

// ===== tma_timer_if.sv
// Signals between the control block and one 16-bit timer.
// Assumes one instance per timer, all on the control block's clock.
`default_nettype none
interface tma_timer_if;
  logic [1:0] mode;
  logic up;
  logic en;
  logic go;
  logic evt;
  logic [15:0] reload;
  logic [15:0] count;
  logic ovf;
  logic out;

  modport ctrl (output mode, up, en, go, evt, reload, input count, ovf, out);
  modport timer (input mode, up, en, go, evt, reload, output count, ovf, out);
endinterface : tma_timer_if
`default_nettype wire

// ===== tma_pin_sync.sv
// Three-flop synchroniser for an external trigger pin, with rising-edge pulse.
// Assumes the pin is asynchronous to clk.
`default_nettype none
module tma_pin_sync
  import tma_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise
);
  tma_sync_type st;
  tma_sync_type next_st;

  // A change counts only once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 1'b0;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
      next_st.rise = st.s3 & ~st.level;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.rise;
endmodule : tma_pin_sync
`default_nettype wire

// ===== tma_timer_core.sv
// One 16-bit general-purpose timer: timer, event, one-shot and pulse modes.
// Assumes the control block supplies mode, direction, enable and event pulses.
`include "tma_map.svh"
`default_nettype none
module tma_timer_core
  import tma_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  tma_timer_if.timer bus
);
  tma_core_type st;
  tma_core_type next_st;
  logic tick;

  // Count step, reload and one-shot run control
  always_comb begin
    next_st = st;
    next_st.ovf = 1'b0;
    case (bus.mode)
      `TMA_MODE_TIMER: tick = bus.en;
      `TMA_MODE_EVENT: tick = bus.en & bus.evt;
      `TMA_MODE_ONESHOT: tick = st.run;
      `TMA_MODE_PWM: tick = bus.en;
      default: tick = 1'b0;
    endcase
    if (!bus.en) begin
      // Stopped: counter follows the reload value
      next_st.count = bus.reload;
      next_st.run = 1'b0;
    end else if (bus.mode == `TMA_MODE_ONESHOT && !st.run) begin
      if (bus.go || bus.evt) begin
        next_st.run = 1'b1;
        next_st.count = bus.reload;
      end
    end else if (tick) begin
      if (bus.up && bus.mode == `TMA_MODE_EVENT) begin
        if (st.count == `TMA_CNT_MAX) begin
          next_st.count = bus.reload;
          next_st.ovf = 1'b1;
        end else begin
          next_st.count = st.count + 16'h0001;
        end
      end else if (st.count == `TMA_CNT_ZERO) begin
        next_st.ovf = 1'b1;
        next_st.out = ~st.out;
        if (bus.mode == `TMA_MODE_ONESHOT) begin
          next_st.run = 1'b0;
        end else begin
          next_st.count = bus.reload;
        end
      end else begin
        next_st.count = st.count - 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.count = st.count;
  assign bus.ovf = st.ovf;
  assign bus.out = st.out;
endmodule : tma_timer_core
`default_nettype wire

// ===== tma_control.sv
// Mode, direction, one-shot start and trigger selection for five 16-bit timers.
// Assumes a byte-wide register port on clk; trigger pins are asynchronous.
//
// Design decision made here: the address-and-strobe port.
`include "tma_map.svh"
`default_nettype none
//
// Operation
// - Five timers, mode from two low bits
// - Timer, event, one-shot, pulse modes supported
// - Direction register 0384, reset 00, 1=up
// - Direction bit used only when selected source
// - Bits 5-7 enable two-phase, write-only
// - One-shot register 0382, writing 1 starts timer
// - One-shot start bits always read zero
// - Timer 0 trigger: pin, invalid, T4, T1
// - Timer 4 trigger: pin, invalid, T3, T0
// - Timer mode divides source by n+1
module tma_control
  import tma_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`TMA_ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic timer0_input_pin,
  input wire logic timer4_input_pin,
  output logic [4:0] timer_out,
  output logic [2:0] quadrature_enable
);
  tma_ctrl_type st;
  tma_ctrl_type next_st;

  logic pin0_rise;
  logic pin4_rise;
  logic [4:0][15:0] count;
  logic [4:0] ovf;
  logic [4:0] tout;
  logic [4:0] evt;
  logic [4:0] up;

  // Trigger pins cross into clk here
  tma_pin_sync u_sync0 (
    .clk(clk),
    .rst(rst),
    .pin(timer0_input_pin),
    .rise(pin0_rise)
  );

  tma_pin_sync u_sync4 (
    .clk(clk),
    .rst(rst),
    .pin(timer4_input_pin),
    .rise(pin4_rise)
  );

  // Event sources in one process, so the vector has a single driver
  always_comb begin
    evt = '0;
    // Timer 0; the invalid code yields no events
    case (st.trig0)
      `TMA_TRIG_PIN: evt[0] = pin0_rise;
      `TMA_TRIG_OVFA: evt[0] = ovf[4];
      `TMA_TRIG_OVFB: evt[0] = ovf[1];
      default: evt[0] = 1'b0;
    endcase
    // Timer 4
    case (st.trig4)
      `TMA_TRIG_PIN: evt[4] = pin4_rise;
      `TMA_TRIG_OVFA: evt[4] = ovf[3];
      `TMA_TRIG_OVFB: evt[4] = ovf[0];
      default: evt[4] = 1'b0;
    endcase
    // Middle timers count their lower neighbour's overflow
    evt[3:1] = ovf[2:0];
  end

  // Direction bit counts only when chosen as source and, for timers 2 to 4, its two-phase enable is off
  always_comb begin
    up = '0;
    for (int i = 0; i < `TMA_NTIMERS; i++) begin
      up[i] = st.dir[i] & ~st.mode[i][`TMA_DSRC_BIT-2];
    end
    up[4:2] = up[4:2] & ~st.quad;
  end

  // One identical timer per channel
  generate
    for (genvar g = 0; g < `TMA_NTIMERS; g++) begin : g_timer
      tma_timer_if tif ();

      assign tif.mode = st.mode[g][`TMA_MODE_MSB:`TMA_MODE_LSB];
      assign tif.up = up[g];
      assign tif.en = st.start[g];
      assign tif.go = st.go[g];
      assign tif.evt = evt[g];
      assign tif.reload = st.reload[g];
      assign count[g] = tif.count;
      assign ovf[g] = tif.ovf;
      assign tout[g] = tif.out;

      tma_timer_core u_core (
        .clk(clk),
        .rst(rst),
        .bus(tif.timer)
      );
    end
  endgenerate

  // Register writes and registered read data
  always_comb begin
    next_st = st;
    // Start bits keep no state: the pulse lasts one cycle
    next_st.go = '0;
    next_st.rdata = `TMA_RESET_BYTE;
    if (wr_en) begin
      case (addr)
        `TMA_A_START: begin
          next_st.start = wr_data[4:0];
        end
        `TMA_A_ONESHOT: begin
          // Zero bits have no effect; ones pulse their timer
          next_st.go = wr_data[4:0];
          next_st.trig0 = wr_data[`TMA_TRIG_MSB:`TMA_TRIG_LSB];
        end
        `TMA_A_TRIG4: begin
          next_st.trig4 = wr_data[`TMA_TRIG_MSB:`TMA_TRIG_LSB];
        end
        `TMA_A_DIR: begin
          // Whole-byte write; write-only bits cannot survive a read-back merge
          next_st.dir = wr_data[4:0];
          next_st.quad = wr_data[`TMA_QUAD_MSB:`TMA_QUAD_LSB];
        end
        default: begin
          for (int i = 0; i < `TMA_NTIMERS; i++) begin
            if (addr == `TMA_A_RELOAD + `TMA_ADDR_W'(2 * i)) begin
              next_st.reload[i][7:0] = wr_data;
            end
            if (addr == `TMA_A_RELOAD + `TMA_ADDR_W'(2 * i + 1)) begin
              next_st.reload[i][15:8] = wr_data;
            end
            if (addr == `TMA_A_MODE + `TMA_ADDR_W'(i)) begin
              next_st.mode[i] = {wr_data[`TMA_DSRC_BIT],
                                 wr_data[`TMA_MODE_MSB:`TMA_MODE_LSB]};
            end
          end
        end
      endcase
    end
    if (rd_en) begin
      case (addr)
        `TMA_A_START: begin
          next_st.rdata = {3'h0, st.start};
        end
        `TMA_A_ONESHOT: begin
          // Start bits and reserved bit always read back as zero
          next_st.rdata = {st.trig0, 6'h00};
        end
        `TMA_A_TRIG4: begin
          next_st.rdata = {st.trig4, 6'h00};
        end
        `TMA_A_DIR: begin
          // Two-phase enables are write-only and read as zero
          next_st.rdata = {3'h0, st.dir};
        end
        default: begin
          for (int i = 0; i < `TMA_NTIMERS; i++) begin
            // Live count; low and high bytes are read separately and may tear
            if (addr == `TMA_A_RELOAD + `TMA_ADDR_W'(2 * i)) begin
              next_st.rdata = count[i][7:0];
            end
            if (addr == `TMA_A_RELOAD + `TMA_ADDR_W'(2 * i + 1)) begin
              next_st.rdata = count[i][15:8];
            end
            if (addr == `TMA_A_MODE + `TMA_ADDR_W'(i)) begin
              next_st.rdata = {3'h0, st.mode[i][2], 2'h0, st.mode[i][1:0]};
            end
          end
        end
      endcase
    end
  end

  // State register; every control field is zero after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come from flip-flops
  assign rd_data = st.rdata;
  assign timer_out = tout;
  assign quadrature_enable = st.quad;
endmodule : tma_control
`default_nettype wire

// ===== tma_checker.sv
// Checker of the register port and two-phase enables of tma_control.
// Assumes it is bound into tma_control; one clock, async active-high reset.
`include "tma_map.svh"
`default_nettype none
module tma_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`TMA_ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic [2:0] quadrature_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A write to a place followed at once by a read of it
  sequence wr_rd(a);
    wr_en && addr == a ##1 rd_en && addr == a;
  endsequence
  // Read data stand for one cycle only
  chk_rd_quiet: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data not idle");
  chk_quad_load: assert property (
    wr_en && addr == `TMA_A_DIR |=> quadrature_enable == $past(wr_data[7:5]))
    else $error("two-phase enables not loaded");
  chk_quad_hold: assert property (
    !(wr_en && addr == `TMA_A_DIR) |=> $stable(quadrature_enable))
    else $error("two-phase enables moved");
  chk_dir_back: assert property (
    wr_rd(`TMA_A_DIR) |=> rd_data == {3'h0, $past(wr_data[4:0], 2)})
    else $error("direction readback wrong");
  chk_go_zero: assert property (
    rd_en && addr == `TMA_A_ONESHOT |=> rd_data[5:0] == 6'h00)
    else $error("start bits not zero");
  chk_trig0_back: assert property (
    wr_rd(`TMA_A_ONESHOT) |=> rd_data[7:6] == $past(wr_data[7:6], 2))
    else $error("timer 0 select wrong");
  chk_trig4_back: assert property (
    wr_rd(`TMA_A_TRIG4) |=> rd_data[7:6] == $past(wr_data[7:6], 2))
    else $error("timer 4 select wrong");
  chk_mode_back: assert property (
    wr_rd(`TMA_A_MODE) |=> rd_data[1:0] == $past(wr_data[1:0], 2))
    else $error("mode readback wrong");
endmodule : tma_checker
`default_nettype wire

// ===== tma_pin_model.sv
// Behavioural source of the two asynchronous trigger pins.
// Assumes the design synchronises the pins and counts rising edges.
`default_nettype none
module tma_pin_model (
  output logic pin0,
  output logic pin4
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins idle low; the device side only listens
  initial begin
    pin0 = 1'b0;
    pin4 = 1'b0;
  end
  // Pulses off the clock grid, long enough for the synchroniser
  task automatic burst(input logic sel4, input int n);
    repeat (n) begin
      #33.3;
      if (sel4) pin4 = 1'b1;
      else pin0 = 1'b1;
      #41.7;
      pin0 = 1'b0;
      pin4 = 1'b0;
    end
  endtask : burst
endmodule : tma_pin_model
`default_nettype wire

// ===== test_timer_a_mode_and_trigger_control.sv
// Self-checking bench of tma_control with a trigger-pin model.
// Assumes design, pin model and checker are compiled first.
`include "tma_map.svh"
`default_nettype none
module test_timer_a_mode_and_trigger_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rv = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wr_data = 8'h00, rd_data;
  logic [4:0] timer_out;
  logic [2:0] quadrature_enable;
  logic pin0, pin4;
  int n_fail = 0, tests_run = 0, seed = 39043;
  logic [7:0] expq[$];

  tma_control tma_control_i (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .timer0_input_pin(pin0),
    .timer4_input_pin(pin4), .timer_out(timer_out), .quadrature_enable(quadrature_enable));
  tma_pin_model tma_pin_model_i (.pin0(pin0), .pin4(pin4));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  // Strobes are set only by nop, wr and rd, so none is driven twice in one step
  task automatic nop(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : nop

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    rd_en <= 1'b0;
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    expq.push_back(e);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
  endtask : rd

  task automatic setup(input int t, input logic [7:0] m, input logic [7:0] r);
    wr(10'(`TMA_A_MODE + t), m);
    wr(10'(`TMA_A_RELOAD + 2 * t), r);
    wr(10'(`TMA_A_RELOAD + 2 * t + 1), 8'h00);
  endtask : setup

  // Cycles until timer output i toggles, bounded
  task automatic gap(input int i, output int c);
    logic b;
    b = timer_out[i];
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (timer_out[i] === b && c < 300);
  endtask : gap

  // Read data meet their noted expectations in order
  always @(posedge clk) begin
    if (rv) check(rd_data, expq.pop_front());
    rv <= rd_en;
  end

  // Watchdog far past the expected run
  initial begin
    #100us;
    n_fail++;
    close_out();
  end

  initial begin
    logic [7:0] d, e;
    logic [1:0] sel;
    logic b;
    int g, n, t, s;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`TMA_A_DIR, 8'h00);
    rd(`TMA_A_ONESHOT, 8'h00);
    check(8'(quadrature_enable), 8'h00);
    repeat (4) begin
      d = 8'($random(seed));
      wr(`TMA_A_DIR, d);
      rd(`TMA_A_DIR, {3'h0, d[4:0]});
      check(8'(quadrature_enable), 8'(d[7:5]));
    end
    wr(`TMA_A_DIR, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`TMA_A_ONESHOT, {2'(k), 6'h1F});
      rd(`TMA_A_ONESHOT, {2'(k), 6'h00});
      wr(`TMA_A_TRIG4, {2'(k), 6'h00});
      rd(`TMA_A_TRIG4, {2'(k), 6'h00});
    end
    for (int i = 0; i < 5; i++) begin
      d = {6'h00, 2'($random(seed))};
      wr(10'(`TMA_A_MODE + i), d);
      rd(10'(`TMA_A_MODE + i), d);
    end
    n = 2 + ($random(seed) & 7);
    setup(1, 8'h00, 8'(n));
    wr(`TMA_A_START, 8'h02);
    nop(1);
    gap(1, g);
    gap(1, g);
    check(8'(g), 8'(n + 1));
    // Pin events: down, up, forced down, then the three non-pin selects idle
    for (int c = 0; c < 6; c++) begin
      for (t = 0; t < 5; t += 4) begin
        sel = c < 3 ? 2'h0 : 2'(c - 2);
        e = (c == 1) ? 8'h43 : (c == 0 || c == 2) ? 8'h3D : 8'h40;
        wr(`TMA_A_START, 8'h00);
        setup(t, {3'h0, c == 2, 2'h0, 2'h1}, 8'h40);
        wr(`TMA_A_DIR, {3'h0, 5'(c == 1 || c == 2) << t});
        wr(t ? `TMA_A_TRIG4 : `TMA_A_ONESHOT, {sel, 6'h00});
        wr(`TMA_A_START, 8'(1 << t));
        nop(5);
        tma_pin_model_i.burst(t == 4, 3);
        nop(10);
        rd(10'(`TMA_A_RELOAD + 2 * t), e);
      end
    end
    // Overflow chains: source period 4, two events per toggle
    wr(`TMA_A_DIR, 8'h00);
    for (int k = 0; k < 4; k++) begin
      t = k < 2 ? 0 : 4;
      s = k == 0 ? 1 : k == 1 ? 4 : k == 2 ? 3 : 0;
      sel = (k == 0 || k == 3) ? 2'h3 : 2'h2;
      wr(`TMA_A_START, 8'h00);
      setup(s, 8'(3 * (k & 1)), 8'h03);
      setup(t, 8'h01, 8'h01);
      wr(t ? `TMA_A_TRIG4 : `TMA_A_ONESHOT, {sel, 6'h00});
      wr(`TMA_A_START, 8'((1 << t) | (1 << s)));
      nop(1);
      gap(t, g);
      gap(t, g);
      check(8'(g), 8'h08);
      if (s == 3) begin
        gap(3, g);
        gap(3, g);
        check(8'(g), 8'h04);
      end
    end
    // One-shot on timer 2, software start only
    wr(`TMA_A_START, 8'h00);
    setup(2, 8'h02, 8'h04);
    wr(`TMA_A_START, 8'h04);
    nop(1);
    b = timer_out[2];
    wr(`TMA_A_ONESHOT, 8'h00);
    nop(20);
    check(8'(timer_out[2]), 8'(b));
    wr(`TMA_A_ONESHOT, 8'h04);
    nop(1);
    gap(2, g);
    check(8'(g < 30), 8'h01);
    nop(40);
    check(8'(timer_out[2]), {7'h00, ~b});
    nop(4);
    close_out();
  end
endmodule : test_timer_a_mode_and_trigger_control

bind tma_control tma_checker tma_checker_i (.clk(clk), .rst(rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .quadrature_enable(quadrature_enable));
`default_nettype wire
